// *** core/fsps_sequencer.v ***
// Flash self-program sequencer: arming, page buffer, erase and write timing
// Operation
// R1: Boot fuse 1 resets to 0x0000, fuse 0 resets to loader start.
// R2: Software has no path to change any fuse.
// R3: Address comes from sixteen-bit pointer, high and low register-file bytes.
// R4: Address is latched when an operation starts.
// R5: Lock-bit setting ignores the pointer entirely.
// R6: Load-program reads bytes, pointer bit zero picks low or high.
// R7: Erase pattern plus store within four cycles erases the addressed page.
// R8: Erase of halting region stalls CPU; readable region erase allows fetches.
// R9: Load pattern plus store writes data word into buffer slot.
// R10: Buffer clears after page write, on region re-enable, and on reset.
// R11: Software loads each buffer slot at most once between clears.
// R12: EEPROM write during page loading discards loaded buffer words.
// R13: Write pattern plus store programs buffer into addressed page.
// R14: Write to halting region stalls CPU; readable region write allows reads.
// R15: Buffer accepts loads in any order, before or after erase.
// R16: Software uses the same page for erase and write.
// R17: Interrupt request holds while enabled and the enable bit is clear.
// R18: During erase or write, readable region is blocked, busy flag set.
// R19: Writing region re-enable after programming clears busy and unblocks.
// R20: Software should protect loader region unless replacing it.
// R21: Armed command clears if no store follows within four cycles.
// R22: A counter from control write times the arming window.
`timescale 1ns/1ps
`include "fsps_map.vh"
module fsps_sequencer #(
  parameter PROG_CYCLES = `FSPS_PROG_CYCLES,
  parameter [15:0] LOADER_START = 16'h1C00
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Fuse and EEPROM status
  input  wire        boot_vector_select_fuse,
  input  wire        eeprom_write,
  // Control register access
  input  wire        ctrl_write,
  input  wire [7:0]  ctrl_wdata,
  output reg  [7:0]  selfprog_control_register,
  // CPU instructions and register file
  input  wire        store_program,
  input  wire        load_program,
  input  wire [7:0]  flash_pointer_high,
  input  wire [7:0]  flash_pointer_low,
  input  wire [7:0]  data_r1,
  input  wire [7:0]  data_r0,
  output reg  [7:0]  load_data,
  output reg         load_valid,
  // CPU control
  output reg  [15:0] reset_vector,
  output reg         cpu_stall,
  output reg         region_blocked,
  output reg         selfprog_irq,
  // Flash array
  output reg         flash_erase,
  output reg         flash_write,
  output reg         flash_lock_set,
  output reg  [9:0]  flash_page,
  output reg  [4:0]  flash_word_index,
  output reg  [15:0] flash_word_data,
  output reg  [7:0]  flash_lock_data,
  output reg         flash_read,
  output reg  [15:0] flash_read_byte_addr,
  input  wire [15:0] flash_read_word
);
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_ERASE = 4'b0010;
  localparam [3:0] S_WRITE = 4'b0100;
  localparam [3:0] S_LOCK  = 4'b1000;

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [4:0]  cmd_reg;
  reg  [2:0]  arm_cnt_reg;
  reg         irq_en_reg;
  reg         busy_reg;
  reg         loading_reg;
  reg  [18:0] time_cnt_reg;
  reg  [4:0]  wr_index_reg;
  reg         read_pend_reg;
  reg         read_hi_reg;
  reg         fuse_seen_reg;
  reg         last_reg;

  wire [15:0] pointer;
  wire [9:0]  ptr_page;
  wire [4:0]  ptr_word;
  wire        idle;
  wire        launch;
  wire        arm_load;
  wire        arm_erase;
  wire        arm_write;
  wire        arm_lock;
  wire        reenable;
  wire        op_done;
  wire        buf_load;
  wire        buf_clear;
  wire [15:0] buf_rdata;
  wire        buf_rvalid;

  // Pointer split into page and word fields
  assign pointer  = {flash_pointer_high, flash_pointer_low}; // [R3]
  assign ptr_page = pointer[`FSPS_PAGE_MSB:`FSPS_PAGE_LSB];
  assign ptr_word = pointer[`FSPS_WORD_MSB:`FSPS_WORD_LSB];

  // Pointer page in the halting region stalls the CPU
  function in_halting;
    input [9:0] page;
    begin
      in_halting = ({page, 6'h00} >= LOADER_START);
    end
  endfunction

  function cmd_is;
    input [4:0] cmd;
    input [4:0] pat;
    begin
      cmd_is = ((cmd & `FSPS_CMD_MASK) == pat);
    end
  endfunction

  assign idle      = (state_reg == S_IDLE);
  assign launch    = store_program && (arm_cnt_reg != 3'h0) && idle; // [R22]
  assign arm_load  = cmd_is(cmd_reg, `FSPS_CMD_LOAD);
  assign arm_erase = cmd_is(cmd_reg, `FSPS_CMD_ERASE);
  assign arm_write = cmd_is(cmd_reg, `FSPS_CMD_WRITE);
  assign arm_lock  = cmd_is(cmd_reg, `FSPS_CMD_LOCKSET);
  assign reenable  = launch && cmd_is(cmd_reg, `FSPS_CMD_REENABLE);
  assign op_done   = !idle && (time_cnt_reg == 19'h00000);
  assign buf_load  = launch && arm_load; // [R9]
  // Page write end, re-enable and EEPROM write while loading clear the buffer
  assign buf_clear = (op_done && (state_reg == S_WRITE)) || reenable
                     || (eeprom_write && loading_reg); // [R10] [R12]

  fsps_page_buffer u_buffer (
    .clk        (clk),
    .reset      (reset),
    .load       (buf_load),
    .load_index (ptr_word),
    .load_data  ({data_r1, data_r0}),
    .clear      (buf_clear),
    .read_index (wr_index_reg),
    .read_data  (buf_rdata),
    .read_valid (buf_rvalid)
  ); // [R15]

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (launch && arm_erase) begin
          state_next = S_ERASE; // [R7]
        end else if (launch && arm_write) begin
          state_next = S_WRITE; // [R13]
        end else if (launch && arm_lock) begin
          state_next = S_LOCK;
        end
      end
      S_ERASE, S_WRITE, S_LOCK: begin
        if (op_done) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg    <= S_IDLE;
      time_cnt_reg <= 19'h00000;
    end else begin
      state_reg <= state_next;
      if (idle && state_next != S_IDLE) begin
        time_cnt_reg <= PROG_CYCLES[18:0] - 19'h00001;
      end else if (!idle && time_cnt_reg != 19'h00000) begin
        time_cnt_reg <= time_cnt_reg - 19'h00001;
      end
    end
  end

  // Control register arming; only software-writable bits, no fuse path [R2]
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_reg     <= 5'h00;
      arm_cnt_reg <= 3'h0;
      irq_en_reg  <= 1'b0;
    end else if (ctrl_write && idle) begin
      cmd_reg     <= ctrl_wdata[4:0];
      irq_en_reg  <= ctrl_wdata[`FSPS_BIT_IRQ_EN];
      arm_cnt_reg <= ctrl_wdata[`FSPS_BIT_ENABLE] ? `FSPS_ARM_CYCLES : 3'h0; // [R22]
    end else if (launch) begin
      arm_cnt_reg <= 3'h0;
      if (arm_load || reenable) begin
        cmd_reg <= 5'h00;
      end
    end else if (arm_cnt_reg != 3'h0) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
      if (arm_cnt_reg == 3'h1) begin
        cmd_reg <= 5'h00; // [R21]
      end
    end else if (op_done) begin
      cmd_reg <= 5'h00;
    end
  end

  // Busy flag set by erase or write, cleared only by re-enable
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_reg    <= 1'b0;
      loading_reg <= 1'b0;
    end else begin
      if (launch && (arm_erase || arm_write)) begin
        busy_reg <= 1'b1; // [R18]
      end else if (reenable) begin
        busy_reg <= 1'b0; // [R19]
      end
      if (buf_clear) begin
        loading_reg <= 1'b0;
      end else if (buf_load) begin
        loading_reg <= 1'b1;
      end
    end
  end

  // Latched operation address and array strobes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_page       <= 10'h000;
      flash_erase      <= 1'b0;
      flash_write      <= 1'b0;
      flash_lock_set   <= 1'b0;
      flash_lock_data  <= 8'hFF;
      flash_word_index <= 5'h00;
      flash_word_data  <= 16'hFFFF;
      wr_index_reg     <= 5'h00;
      last_reg         <= 1'b0;
      cpu_stall        <= 1'b0;
    end else begin
      flash_erase    <= 1'b0;
      flash_lock_set <= 1'b0;
      if (launch && (arm_erase || arm_write)) begin
        flash_page <= ptr_page; // [R4]
        cpu_stall  <= in_halting(ptr_page); // [R8] [R14]
      end else if (op_done) begin
        cpu_stall <= 1'b0;
      end
      if (launch && arm_erase) begin
        flash_erase <= 1'b1;
      end
      if (launch && arm_lock) begin
        flash_lock_set  <= 1'b1; // [R5]
        flash_lock_data <= data_r0;
      end
      // Page write streams buffer words to the array, one per cycle;
      // the strobe stays up one cycle past the last word so word 31 is seen
      if (launch && arm_write) begin
        flash_write  <= 1'b1;
        wr_index_reg <= 5'h00;
        last_reg     <= 1'b0;
      end else if (flash_write) begin
        if (last_reg) begin
          flash_write <= 1'b0;
          last_reg    <= 1'b0;
        end else begin
          flash_word_index <= wr_index_reg;
          flash_word_data  <= buf_rvalid ? buf_rdata : 16'hFFFF;
          wr_index_reg     <= wr_index_reg + 5'h01;
          last_reg         <= (wr_index_reg == 5'h1F);
        end
      end
    end
  end

  // Byte read by load-program
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_read           <= 1'b0;
      flash_read_byte_addr <= 16'h0000;
      read_pend_reg        <= 1'b0;
      read_hi_reg          <= 1'b0;
      load_data            <= 8'h00;
      load_valid           <= 1'b0;
    end else begin
      flash_read    <= load_program;
      read_pend_reg <= load_program;
      load_valid    <= read_pend_reg;
      if (load_program) begin
        flash_read_byte_addr <= pointer;
        read_hi_reg          <= pointer[0];
      end
      if (read_pend_reg) begin
        load_data <= read_hi_reg ? flash_read_word[15:8] : flash_read_word[7:0]; // [R6]
      end
    end
  end

  // Status view, interrupt level and reset vector
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      selfprog_control_register <= 8'h00;
      selfprog_irq              <= 1'b0;
      region_blocked            <= 1'b0;
      reset_vector              <= `FSPS_APP_VECTOR;
      fuse_seen_reg             <= 1'b0;
    end else begin
      selfprog_control_register <= {irq_en_reg, busy_reg, 1'b0, cmd_reg};
      selfprog_irq   <= irq_en_reg && !cmd_reg[`FSPS_BIT_ENABLE]; // [R17]
      region_blocked <= busy_reg; // [R18]
      if (!fuse_seen_reg) begin
        fuse_seen_reg <= 1'b1;
        reset_vector  <= boot_vector_select_fuse ? `FSPS_APP_VECTOR : LOADER_START; // [R1]
      end
    end
  end
endmodule // fsps_sequencer

// *** core/fsps_map.vh ***
// Constants for the flash self-program sequencer
`ifndef FSPS_MAP_VH
`define FSPS_MAP_VH
// Control register bit positions
`define FSPS_BIT_ENABLE      0
`define FSPS_BIT_ERASE       1
`define FSPS_BIT_WRITE       2
`define FSPS_BIT_LOCKSET     3
`define FSPS_BIT_REENABLE    4
`define FSPS_BIT_BUSY        6
`define FSPS_BIT_IRQ_EN      7
// Command patterns in the five low bits
`define FSPS_CMD_MASK        5'h1F
`define FSPS_CMD_LOAD        5'h01
`define FSPS_CMD_ERASE       5'h03
`define FSPS_CMD_WRITE       5'h05
`define FSPS_CMD_LOCKSET     5'h09
`define FSPS_CMD_REENABLE    5'h11
// Arming window in cycles
`define FSPS_ARM_CYCLES      3'h4
// Pointer fields: word [5:1], page [15:6]
`define FSPS_WORD_LSB        1
`define FSPS_WORD_MSB        5
`define FSPS_PAGE_LSB        6
`define FSPS_PAGE_MSB        15
`define FSPS_WORDS           32
// Flash operation time, 3.2 ms minimum at 100 MHz
`define FSPS_PROG_TIME_US    3200
`define FSPS_PROG_CYCLES     (`FSPS_PROG_TIME_US * 100)
// Application reset address
`define FSPS_APP_VECTOR      16'h0000
`endif

// *** core/fsps_page_buffer.v ***
// Temporary page buffer of sixteen-bit words with per-word load tracking
`timescale 1ns/1ps
module fsps_page_buffer (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Load port
  input  wire        load,
  input  wire [4:0]  load_index,
  input  wire [15:0] load_data,
  // Clear
  input  wire        clear,
  // Read port
  input  wire [4:0]  read_index,
  output wire [15:0] read_data,
  output wire        read_valid
);
  reg [15:0] word_mem [0:31];
  reg [31:0] loaded_reg;
  integer i;

  // Any order of loads is accepted; clear drops all loaded words
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      loaded_reg <= 32'h00000000;
    end else if (clear) begin
      loaded_reg <= 32'h00000000;
    end else if (load) begin
      loaded_reg[load_index] <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (load && !clear) begin
      word_mem[load_index] <= load_data;
    end
  end

  // Unloaded words read as erased flash
  assign read_valid = loaded_reg[read_index];
  assign read_data  = loaded_reg[read_index] ? word_mem[read_index] : 16'hFFFF;
endmodule // fsps_page_buffer

// *** test/fsps_sva.sv ***
// Assertion checker for the flash self-program sequencer
`timescale 1ns/1ps
module fsps_sva #(
  parameter PROG_CYCLES = 50,
  parameter [15:0] LOADER_START = 16'h1C00
) (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // CPU side
  input wire        ctrl_write,
  input wire [7:0]  ctrl_wdata,
  input wire [7:0]  selfprog_control_register,
  input wire        store_program,
  input wire        load_program,
  input wire        load_valid,
  input wire        cpu_stall,
  input wire        region_blocked,
  input wire        selfprog_irq,
  // Flash side
  input wire        flash_write,
  input wire        flash_erase,
  input wire [9:0]  flash_page,
  input wire [4:0]  flash_word_index
);
  reg [7:0] wcnt_reg;
  // Length of the current buffer transfer burst
  always @(posedge clk or posedge reset) begin
    if (reset) wcnt_reg <= 8'h00;
    else wcnt_reg <= flash_write ? wcnt_reg + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_arm(pat);
    ctrl_write && ctrl_wdata[4:0] == pat && !flash_write && !cpu_stall;
  endsequence
  sequence s_go(pat);
    s_arm(pat) ##[1:4] store_program;
  endsequence
  property p_erase; s_go(5'h03) |-> ##1 flash_erase; endproperty
  property p_write; s_go(5'h05) |-> ##1 flash_write; endproperty
  property p_expire;
    s_arm(5'h05) ##1 (!store_program)[*4] |-> ##1 (!flash_write)[*3];
  endproperty
  property p_wlen; $fell(flash_write) |-> wcnt_reg == 8'h21; endproperty
  property p_index;
    flash_write && $past(flash_write, 2) |->
      flash_word_index == $past(flash_word_index) + 5'h01;
  endproperty
  property p_latch; flash_write && $past(flash_write) |-> $stable(flash_page); endproperty
  property p_stall;
    $rose(flash_write) || $rose(flash_erase) |->
      cpu_stall == ({flash_page, 6'h00} >= LOADER_START);
  endproperty
  property p_busy;
    $rose(flash_write) || $rose(flash_erase) |->
      ##[1:2] selfprog_control_register[6] && region_blocked;
  endproperty
  property p_irq;
    (selfprog_control_register[7] && !selfprog_control_register[0])[*2] |-> selfprog_irq;
  endproperty
  property p_load; load_program |-> ##2 load_valid; endproperty
  a_erase: assert property (p_erase) else $error("erase did not start");
  a_write: assert property (p_write) else $error("write did not start");
  a_expire: assert property (p_expire) else $error("late store launched");
  a_wlen: assert property (p_wlen) else $error("write burst length wrong");
  a_index: assert property (p_index) else $error("word index not stepping");
  a_latch: assert property (p_latch) else $error("page moved during write");
  a_stall: assert property (p_stall) else $error("stall disagrees with region");
  a_busy: assert property (p_busy) else $error("busy not raised");
  a_irq: assert property (p_irq) else $error("interrupt missing");
  a_load: assert property (p_load) else $error("load answer late");
endmodule // fsps_sva

// *** test/fsps_flash_model.sv ***
// Flash array read model answering the sequencer's read strobe
`timescale 1ns/1ps
module fsps_flash_model (
  // Clock
  input  wire        clk,
  // Read port
  input  wire        flash_read,
  input  wire [15:0] flash_read_byte_addr,
  output wire [15:0] flash_read_word
);
  reg        hold_reg = 1'b0;
  reg [15:0] junk_reg = 16'hA5A5;
  // Word is valid for the strobe and the next cycle, scrambled otherwise
  always @(posedge clk) begin
    hold_reg <= flash_read;
    junk_reg <= ~flash_read_word;
  end
  assign flash_read_word = (flash_read | hold_reg) ?
    ({flash_read_byte_addr[15:1], 1'b0} ^ 16'hC35A) : junk_reg;
endmodule // fsps_flash_model

// *** test/testbench.sv ***
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
module testbench;
  localparam PC = 50;
  localparam [15:0] LS = 16'h1C00;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         fuse = 1'b1;
  reg         eeprom_write = 1'b0;
  reg         ctrl_write = 1'b0;
  reg  [7:0]  ctrl_wdata = 8'h00;
  reg         store_program = 1'b0;
  reg         load_program = 1'b0;
  reg  [15:0] z = 16'h0000;
  reg  [15:0] d = 16'h0000;
  reg  [15:0] got [0:31];
  wire [7:0]  ctrl_reg;
  wire [7:0]  load_data;
  wire [15:0] rv;
  wire [15:0] fwd;
  wire [15:0] rba;
  wire [15:0] frw;
  wire [9:0]  page;
  wire [4:0]  widx;
  wire        load_valid;
  wire        cpu_stall;
  wire        region_blocked;
  wire        irq;
  wire        fw;
  wire        fr;
  integer     checks = 0;
  integer     n_errors = 0;
  integer     i;
  integer     n;
  always #5 clk = ~clk;
  fsps_sequencer #(.PROG_CYCLES(PC), .LOADER_START(LS)) uut (
    .clk(clk), .reset(reset), .boot_vector_select_fuse(fuse), .eeprom_write(eeprom_write),
    .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .selfprog_control_register(ctrl_reg),
    .store_program(store_program), .load_program(load_program),
    .flash_pointer_high(z[15:8]), .flash_pointer_low(z[7:0]), .data_r1(d[15:8]),
    .data_r0(d[7:0]), .load_data(load_data), .load_valid(load_valid), .reset_vector(rv),
    .cpu_stall(cpu_stall), .region_blocked(region_blocked), .selfprog_irq(irq),
    .flash_erase(), .flash_write(fw), .flash_lock_set(), .flash_page(page),
    .flash_word_index(widx), .flash_word_data(fwd), .flash_lock_data(), .flash_read(fr),
    .flash_read_byte_addr(rba), .flash_read_word(frw));
  fsps_flash_model u_flash (.clk(clk), .flash_read(fr), .flash_read_byte_addr(rba),
    .flash_read_word(frw));
  function [15:0] wd(input [4:0] x);
    wd = {3'h5, x, 3'h0, x} ^ 16'h00A6;
  endfunction
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One cycle of a bounded wait; running out ends the run
  task step(inout integer k, input integer lim);
    begin
      @(posedge clk);
      #1;
      k = k + 1;
      if (k >= lim) begin
        n_errors = n_errors + 1;
        finish_test;
      end
    end
  endtask
  task cmd(input [7:0] v, input go);
    begin
      @(posedge clk);
      ctrl_write <= 1'b1;
      ctrl_wdata <= v;
      @(posedge clk);
      ctrl_write <= 1'b0;
      store_program <= go;
      @(posedge clk);
      store_program <= 1'b0;
    end
  endtask
  task wait_done;
    integer k;
    begin
      k = 0;
      step(k, 400);
      while (ctrl_reg[0] !== 1'b0) step(k, 400);
    end
  endtask
  task do_reset(input f);
    begin
      @(posedge clk);
      fuse <= f;
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(rv, f ? 16'h0000 : LS);
    end
  endtask
  // Page write from pointer a, capturing every streamed word
  task wr_page(input [15:0] a);
    begin
      @(posedge clk);
      z <= a;
      cmd(8'h05, 1'b1);
      z <= 16'hFFFF;
      n = 0;
      while (fw !== 1'b1) step(n, 10);
      while (fw === 1'b1) begin
        got[widx] = fwd;
        step(n, 60);
      end
    end
  endtask
  task lpm(input [15:0] a, input [7:0] e);
    integer k;
    begin
      @(posedge clk);
      z <= a;
      load_program <= 1'b1;
      @(posedge clk);
      load_program <= 1'b0;
      k = 0;
      while (load_valid !== 1'b1) step(k, 8);
      chk(load_data, e);
    end
  endtask
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    $display("test reset vector done");
    for (i = 31; i >= 0; i = i - 1) begin
      @(posedge clk);
      z <= {10'h005, i[4:0], 1'b0};
      d <= wd(i[4:0]);
      cmd(8'h01, 1'b1);
    end
    z <= 16'h0140;
    cmd(8'h03, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk(cpu_stall, 1'b0);
    wait_done;
    wr_page(16'h0140);
    chk(page, 10'h005);
    chk(cpu_stall, 1'b0);
    chk(region_blocked, 1'b1);
    for (i = 0; i < 32; i = i + 1) chk(got[i], wd(i[4:0]));
    wait_done;
    cmd(8'h11, 1'b1);
    wait_done;
    chk(region_blocked, 1'b0);
    $display("test page write done");
    cmd(8'h05, 1'b0);
    repeat (4) @(posedge clk);
    store_program <= 1'b1;
    @(posedge clk);
    store_program <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_reg[4:0], 5'h00);
    chk(fw, 1'b0);
    $display("test arming expiry done");
    @(posedge clk);
    z <= LS;
    cmd(8'h83, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk(cpu_stall, 1'b1);
    chk(ctrl_reg[6], 1'b1);
    chk(irq, 1'b0);
    wait_done;
    repeat (2) @(posedge clk);
    #1;
    chk(cpu_stall, 1'b0);
    chk(irq, 1'b1);
    cmd(8'h11, 1'b1);
    wait_done;
    chk(region_blocked, 1'b0);
    $display("test halting erase done");
    @(posedge clk);
    z <= 16'h0146;
    d <= 16'h1234;
    cmd(8'h01, 1'b1);
    @(posedge clk);
    eeprom_write <= 1'b1;
    @(posedge clk);
    eeprom_write <= 1'b0;
    z <= 16'h0148;
    d <= 16'h4321;
    cmd(8'h01, 1'b1);
    wr_page(16'h0140);
    chk(got[3], 16'hFFFF);
    chk(got[4], 16'h4321);
    chk(got[0], 16'hFFFF);
    $display("test buffer loss done");
    lpm(16'h0247, 8'hC1);
    lpm(16'h0246, 8'h1C);
    $display("test byte read done");
    finish_test;
  end
endmodule // testbench
bind fsps_sequencer fsps_sva #(.PROG_CYCLES(PROG_CYCLES), .LOADER_START(LOADER_START))
  u_sva (.*);
